// File: hw/tis_sorter.v
// track input sorter: masking, ranking of eighteen segments, test replay and result buffers
`timescale 1ns/1ps
`include "tis_consts.vh"

module tis_sorter #(
  parameter NB    = 9,
  parameter DEPTH = `TIS_BUF_DEPTH,
  parameter AW    = 9
) (
  input  wire             CLK,
  input  wire             RST,
  input  wire             PSEL,
  input  wire             PENABLE,
  input  wire             PWRITE,
  input  wire [7:0]       PADDR,
  input  wire [31:0]      PWDATA,
  output reg  [31:0]      PRDATA,
  output reg              PREADY,
  output reg              PSLVERR,
  input  wire [NB*32-1:0] SRC_LINES,
  input  wire             REPLAY_CMD,
  output reg  [15:0]      OUT_FRAME0,
  output reg  [15:0]      OUT_FRAME1,
  output reg  [15:0]      OUT_FRAME2,
  output reg              OUT_SECOND_FRAME
);

  localparam NS = 2 * NB;
  localparam SW = `TIS_SCORE_W;
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_ARM  = 3'h2;
  localparam [2:0] ST_RUN  = 3'h4;

  // ----------------------------------------------------------------
  // pin synchronisers and frame phase
  // ----------------------------------------------------------------
  reg [NB*32-1:0] src_s1;
  reg [NB*32-1:0] src_s2;
  reg             cmd_s1;
  reg             cmd_s2;
  reg             cmd_s3;
  reg             phase;

  always @(posedge CLK) begin
    src_s1 <= SRC_LINES;
    src_s2 <= src_s1;
    cmd_s1 <= REPLAY_CMD;
    cmd_s2 <= cmd_s1;
    cmd_s3 <= cmd_s2;
  end

  // phase 0 carries the first frame of each segment pair
  always @(posedge CLK) begin
    if (RST) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  reg  [15:0]   mask;
  reg           mode;
  reg           buf_clr;
  reg  [2:0]    state;
  reg  [31:0]   rd_mux;
  reg           unmapped;
  wire          access   = PSEL & PENABLE;
  wire          done     = access & PREADY;
  wire          busy     = (state != ST_IDLE);
  wire          in_hit   = (PADDR[7:6] == 2'b01) && (PADDR[5:2] < NB) && (PADDR[1:0] == 2'b00);
  wire          res_hit  = (PADDR[7:4] == 4'h8) && (PADDR[3:2] != 2'b11) && (PADDR[1:0] == 2'b00);
  wire [3:0]    in_sel   = PADDR[5:2];
  wire [1:0]    res_sel  = PADDR[3:2];
  wire          ctrl_wr  = done & PWRITE & (PADDR == `TIS_OFF_CTRL);
  wire          rep_req  = (ctrl_wr & PWDATA[`TIS_CTRL_REPLAY]) | (cmd_s2 & ~cmd_s3);
  wire [NB-1:0] ib_empty;
  wire [NB-1:0] ib_full;
  wire [NB*32-1:0] ib_word;
  wire [2:0]    rb_empty;
  wire [2:0]    rb_full;
  wire [47:0]   rb_word;
  always @* begin
    rd_mux   = 32'h0000_0000;
    unmapped = 1'b0;
    if (PADDR == `TIS_OFF_CTRL) begin
      rd_mux[`TIS_CTRL_MODE] = mode;
    end else if (PADDR == `TIS_OFF_MASK) begin
      rd_mux[15:0] = mask;
    end else if (PADDR == `TIS_OFF_STAT) begin
      rd_mux = {7'h00, busy, rb_full, rb_empty, ib_full, ib_empty};
    end else if (in_hit) begin
      rd_mux   = ib_word[in_sel*32 +: 32];
      unmapped = busy;
    end else if (res_hit) begin
      rd_mux[15:0] = rb_word[res_sel*16 +: 16];
    end else begin
      unmapped = 1'b1;
    end
  end
  // two-cycle access: data and error are registered with the ready
  always @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= access & ~PREADY;
      PSLVERR <= access & ~PREADY & unmapped;
      if (access & ~PREADY & ~PWRITE) begin
        PRDATA <= rd_mux;
      end
    end
  end
  always @(posedge CLK) begin
    if (RST) begin
      mask    <= `TIS_MASK_RST;
      mode    <= 1'b0;
      buf_clr <= 1'b0;
    end else begin
      buf_clr <= ctrl_wr & PWDATA[`TIS_CTRL_BUFCLR];
      if (ctrl_wr) begin
        mode <= PWDATA[`TIS_CTRL_MODE];
      end
      if (done & PWRITE & (PADDR == `TIS_OFF_MASK)) begin
        mask <= PWDATA[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // replay sequencer
  // ----------------------------------------------------------------
  // replay starts on a first-frame cycle so buffer words pair with frames
  always @(posedge CLK) begin
    if (RST | buf_clr) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (rep_req & mode) begin
            state <= ST_ARM;
          end
        end
        ST_ARM: begin
          if (phase) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (~phase & (&ib_empty)) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // input test buffers
  // ----------------------------------------------------------------
  wire [NB*32-1:0] rep_lines;
  genvar gi;
  generate
    for (gi = 0; gi < NB; gi = gi + 1) begin : g_in
      reg  [31:0]   mem [0:DEPTH-1];
      reg  [AW-1:0] wp;
      reg  [AW-1:0] rp;
      reg  [AW:0]   cnt;
      wire          hit  = done & in_hit & (in_sel == gi) & ~busy;
      wire          push = hit & PWRITE & ~ib_full[gi];
      wire          pop  = ~ib_empty[gi] & ((state == ST_RUN) | (hit & ~PWRITE));
      always @(posedge CLK) begin
        if (push) begin
          mem[wp] <= PWDATA;
        end
      end
      always @(posedge CLK) begin
        if (RST | buf_clr) begin
          wp  <= {AW{1'b0}};
          rp  <= {AW{1'b0}};
          cnt <= {(AW+1){1'b0}};
        end else begin
          if (push) begin
            wp <= (wp == DEPTH - 1) ? {AW{1'b0}} : wp + 1'b1;
          end
          if (pop) begin
            rp <= (rp == DEPTH - 1) ? {AW{1'b0}} : rp + 1'b1;
          end
          cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
      end
      assign ib_word[gi*32 +: 32] = mem[rp];
      assign ib_empty[gi]         = (cnt == 0);
      assign ib_full[gi]          = (cnt == DEPTH);
      // buffer keeps segment zero high, the lines carry it low
      assign rep_lines[gi*32 +: 32] = (state == ST_RUN && !ib_empty[gi]) ?
                                      {mem[rp][15:0], mem[rp][31:16]} : 32'h0000_0000;
    end
  endgenerate

  // ----------------------------------------------------------------
  // candidate scoring and ranking
  // ----------------------------------------------------------------
  wire [NB*32-1:0] src = mode ? rep_lines : src_s2;
  reg  [NB*32-1:0] first;
  wire [NS*SW-1:0] score;
  genvar gc;
  generate
    for (gc = 0; gc < NS; gc = gc + 1) begin : g_score
      wire [15:0] f1   = first[gc*16 +: 16];
      wire [3:0]  qual = f1[`TIS_F1_QUAL_HI:`TIS_F1_QUAL_LO];
      // cancelled or masked candidates score zero and can never win
      wire        live = mask[gc/2] & (f1[`TIS_F1_VALID] | (qual != 4'h0));
      wire [31:0] brd  = gc / 2;
      wire        seg0 = (gc % 2) == 0;
      // quality first, then board number, then segment zero
      assign score[gc*SW +: SW] = live ? {1'b1, qual, brd[3:0], seg0} : {SW{1'b0}};
    end
  endgenerate

  reg [SW-1:0] best0;
  reg [SW-1:0] best1;
  reg [SW-1:0] best2;
  reg [4:0]    idx0;
  reg [4:0]    idx1;
  reg [4:0]    idx2;
  integer      c;
  // scores are unique, so each next pick is the largest below the last
  always @* begin
    best0 = {SW{1'b0}};
    best1 = {SW{1'b0}};
    best2 = {SW{1'b0}};
    idx0  = 5'h00;
    idx1  = 5'h00;
    idx2  = 5'h00;
    for (c = 0; c < NS; c = c + 1) begin
      if (score[c*SW +: SW] > best0) begin
        best0 = score[c*SW +: SW];
        idx0  = c[4:0];
      end
    end
    for (c = 0; c < NS; c = c + 1) begin
      if (score[c*SW +: SW] < best0 && score[c*SW +: SW] > best1) begin
        best1 = score[c*SW +: SW];
        idx1  = c[4:0];
      end
    end
    for (c = 0; c < NS; c = c + 1) begin
      if (score[c*SW +: SW] < best1 && score[c*SW +: SW] > best2) begin
        best2 = score[c*SW +: SW];
        idx2  = c[4:0];
      end
    end
  end

  // empty slots carry zero frames
  wire [15:0] pick1_0 = (best0 != 0) ? first[idx0*16 +: 16] : 16'h0000;
  wire [15:0] pick1_1 = (best1 != 0) ? first[idx1*16 +: 16] : 16'h0000;
  wire [15:0] pick1_2 = (best2 != 0) ? first[idx2*16 +: 16] : 16'h0000;
  wire [15:0] pick2_0 = (best0 != 0) ? src[idx0*16 +: 16] : 16'h0000;
  wire [15:0] pick2_1 = (best1 != 0) ? src[idx1*16 +: 16] : 16'h0000;
  wire [15:0] pick2_2 = (best2 != 0) ? src[idx2*16 +: 16] : 16'h0000;
  wire        top_wr  = pick1_0[`TIS_F1_VALID];
  // ----------------------------------------------------------------
  // output frames
  // ----------------------------------------------------------------
  reg [47:0] hold;
  reg        wr_second;
  always @(posedge CLK) begin
    if (RST) begin
      first            <= {(NB*32){1'b0}};
      hold             <= 48'h0000_0000_0000;
      wr_second        <= 1'b0;
      OUT_FRAME0       <= 16'h0000;
      OUT_FRAME1       <= 16'h0000;
      OUT_FRAME2       <= 16'h0000;
      OUT_SECOND_FRAME <= 1'b0;
    end else begin
      OUT_SECOND_FRAME <= ~phase;
      if (!phase) begin
        first      <= src;
        OUT_FRAME0 <= hold[15:0];
        OUT_FRAME1 <= hold[31:16];
        OUT_FRAME2 <= hold[47:32];
        wr_second  <= 1'b0;
      end else begin
        OUT_FRAME0 <= pick1_0;
        OUT_FRAME1 <= pick1_1;
        OUT_FRAME2 <= pick1_2;
        hold       <= {pick2_2, pick2_1, pick2_0};
        wr_second  <= top_wr & ~buf_clr;  // a clear must not leave half an event behind
      end
    end
  end

  // ----------------------------------------------------------------
  // result buffers
  // ----------------------------------------------------------------
  // first frame is written on the ranking edge, second one an edge later
  wire        sort_we  = phase ? top_wr : wr_second;
  wire [47:0] sort_din = phase ? {pick1_2, pick1_1, pick1_0} : hold;
  genvar gr;
  generate
    for (gr = 0; gr < 3; gr = gr + 1) begin : g_res
      reg  [15:0]   mem [0:DEPTH-1];
      reg  [AW-1:0] wp;
      reg  [AW-1:0] rp;
      reg  [AW:0]   cnt;
      wire          hit  = done & res_hit & (res_sel == gr);
      // sorter owns the write port; a bus write in the same cycle is lost
      wire          push = ~rb_full[gr] & (sort_we | (hit & PWRITE));
      wire          pop  = ~rb_empty[gr] & hit & ~PWRITE;
      wire [15:0]   din  = sort_we ? sort_din[gr*16 +: 16] : PWDATA[15:0];
      always @(posedge CLK) begin
        if (push) begin
          mem[wp] <= din;
        end
      end
      always @(posedge CLK) begin
        if (RST | buf_clr) begin
          wp  <= {AW{1'b0}};
          rp  <= {AW{1'b0}};
          cnt <= {(AW+1){1'b0}};
        end else begin
          if (push) begin
            wp <= (wp == DEPTH - 1) ? {AW{1'b0}} : wp + 1'b1;
          end
          if (pop) begin
            rp <= (rp == DEPTH - 1) ? {AW{1'b0}} : rp + 1'b1;
          end
          cnt <= cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
      end
      assign rb_word[gr*16 +: 16] = mem[rp];
      assign rb_empty[gr]         = (cnt == 0);
      assign rb_full[gr]          = (cnt == DEPTH);
    end
  endgenerate
endmodule // tis_sorter

// File: inc/tis_consts.vh
// register map, field positions and reset values of the track input sorter
`ifndef TIS_CONSTS_VH
`define TIS_CONSTS_VH
`define TIS_OFF_CTRL     8'h00
`define TIS_OFF_MASK     8'h04
`define TIS_OFF_STAT     8'h08
`define TIS_OFF_INBUF    8'h40
`define TIS_OFF_RESBUF   8'h80
`define TIS_MASK_RST     16'hFFFF
`define TIS_CTRL_MODE    0
`define TIS_CTRL_REPLAY  1
`define TIS_CTRL_BUFCLR  2
`define TIS_F1_VALID     15
`define TIS_F1_QUAL_HI   14
`define TIS_F1_QUAL_LO   11
`define TIS_BUF_DEPTH    511
`define TIS_SCORE_W      10
`define TIS_STAT_BUSY    24
`endif

// File: tb/tis_chk.sv
// checker: bus handshake, mask read-back and rank order at the sorter ports
`timescale 1ns/1ps
`include "tis_consts.vh"
module tis_chk #(
  parameter NB = 9
) (
  input logic             CLK,
  input logic             RST,
  input logic             PSEL,
  input logic             PENABLE,
  input logic             PWRITE,
  input logic [7:0]       PADDR,
  input logic [31:0]      PWDATA,
  input logic [31:0]      PRDATA,
  input logic             PREADY,
  input logic             PSLVERR,
  input logic [NB*32-1:0] SRC_LINES,
  input logic             REPLAY_CMD,
  input logic [15:0]      OUT_FRAME0,
  input logic [15:0]      OUT_FRAME1,
  input logic [15:0]      OUT_FRAME2,
  input logic             OUT_SECOND_FRAME
);
  logic [15:0] mask_m;
  logic        done;
  logic        mapped;
  assign done   = PSEL && PENABLE && PREADY;
  assign mapped = (PADDR inside {8'h00, 8'h04, 8'h08, 8'h80, 8'h84, 8'h88}) ||
                  (PADDR >= 8'h40 && PADDR <= 8'h60 && PADDR[1:0] == 2'b00);
  always @(posedge CLK) begin
    if (RST) begin
      mask_m <= `TIS_MASK_RST;
    end else if (done && PWRITE && PADDR == `TIS_OFF_MASK) begin
      mask_m <= PWDATA[15:0];
    end
  end
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_ready_one_after: assert property ($rose(PSEL && PENABLE) |=> PREADY) else $error("ready late");
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready too long");
  a_err_with_ready: assert property (PSLVERR |-> done) else $error("stray error");
  a_unmapped_err: assert property (done && !mapped |-> PSLVERR) else $error("unmapped accepted");
  a_mask_read_back: assert property (done && !PWRITE && PADDR == `TIS_OFF_MASK |-> PRDATA[15:0] == mask_m)
    else $error("mask read wrong");
  a_frame_alternate: assert property (OUT_SECOND_FRAME |=> !OUT_SECOND_FRAME) else $error("frame phase");
  a_rank_order: assert property (!OUT_SECOND_FRAME |-> OUT_FRAME0[14:11] >= OUT_FRAME1[14:11] &&
    OUT_FRAME1[14:11] >= OUT_FRAME2[14:11]) else $error("rank order");
  a_empty_tail: assert property (!OUT_SECOND_FRAME |-> (OUT_FRAME0 != 16'h0 || OUT_FRAME1 == 16'h0) &&
    (OUT_FRAME1 != 16'h0 || OUT_FRAME2 == 16'h0)) else $error("gap in ranks");
  a_no_cancelled: assert property (!OUT_SECOND_FRAME && OUT_FRAME0[15:11] == 5'h0 |-> OUT_FRAME0 == 16'h0)
    else $error("cancelled ranked");
  a_empty_second: assert property (OUT_SECOND_FRAME && $past(OUT_FRAME0) == 16'h0 |-> OUT_FRAME0 == 16'h0)
    else $error("empty slot second");
  c_write: cover property (done && PWRITE);
  c_refused: cover property (PSLVERR);
  c_three_valid: cover property (!OUT_SECOND_FRAME && OUT_FRAME2[15]);
endmodule // tis_chk
bind tis_sorter tis_chk #(.NB(NB)) u_chk (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_LINES(SRC_LINES), .REPLAY_CMD(REPLAY_CMD),
  .OUT_FRAME0(OUT_FRAME0), .OUT_FRAME1(OUT_FRAME1), .OUT_FRAME2(OUT_FRAME2), .OUT_SECOND_FRAME(OUT_SECOND_FRAME));

// File: tb/tis_src_model.sv
// partner model: nine source boards streaming segment pairs as first and second frames
`timescale 1ns/1ps
module tis_src_model #(
  parameter int NB = 9
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [NB*32-1:0] first_frames,
  input  wire logic [NB*32-1:0] second_frames,
  output logic      [NB*32-1:0] lines
);
  logic             sec = 1'b0;
  logic [NB*32-1:0] held;
  // ---------------------------------------------------------------
  // frame pairing
  // ---------------------------------------------------------------
  // the pair is latched whole, so a change of stimulus never tears a first frame from its second
  always @(posedge clk) begin
    if (rst || !sec) begin
      lines <= first_frames;
      held  <= second_frames;
      sec   <= 1'b1;
    end else begin
      lines <= held;
      sec   <= 1'b0;
    end
  end
endmodule // tis_src_model

// File: tb/track_input_sorter_test_fifos_tb_top.sv
// testbench: register access, live ranking and replay into the result buffers
`timescale 1ns/1ps
`include "tis_consts.vh"
module track_input_sorter_test_fifos_tb_top;
  localparam int NB = 9;
  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic             replay_cmd = 1'b0;
  logic [NB*32-1:0] f1 = '0;
  logic [NB*32-1:0] f2 = '0;
  logic [NB*32-1:0] a;
  logic [NB*32-1:0] b;
  wire  [NB*32-1:0] lines;
  wire  [31:0]      prdata;
  wire              pready, pslverr, osf;
  wire  [15:0]      o0, o1, o2;
  logic [31:0]      rdat;
  logic             rerr;
  logic [47:0]      x1, x2;
  int               err_count = 0;
  int               checks = 0;
  initial forever #10 clk = ~clk;
  tis_src_model #(.NB(NB)) u_src (.clk(clk), .rst(rst), .first_frames(f1), .second_frames(f2), .lines(lines));
  tis_sorter #(.NB(NB)) u_dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .SRC_LINES(lines), .REPLAY_CMD(replay_cmd),
    .OUT_FRAME0(o0), .OUT_FRAME1(o1), .OUT_FRAME2(o2), .OUT_SECOND_FRAME(osf));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic results;
    if (err_count == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin err_count++; results(); end
    rdat = prdata; rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // candidates scanned from the highest board down, segment zero before segment one
  function automatic void rank(input logic [NB*32-1:0] p, input logic [NB*32-1:0] q, input logic [15:0] m,
                               output logic [47:0] e1, output logic [47:0] e2);
    logic [2*NB-1:0] used;
    logic [15:0]     f;
    int              bq, bc, k;
    used = '0; e1 = '0; e2 = '0;
    for (int r = 0; r < 3; r++) begin
      bq = -1; bc = 0;
      for (int c = 2*NB-1; c >= 0; c--) begin
        k = c ^ 1;
        f = p[k*16 +: 16];
        if (m[k/2] && !used[k] && (f[14:11] != 4'h0 || f[15]) && int'(f[14:11]) > bq) begin
          bq = int'(f[14:11]); bc = k;
        end
      end
      if (bq >= 0) begin
        used[bc] = 1'b1;
        e1[r*16 +: 16] = p[bc*16 +: 16];
        e2[r*16 +: 16] = q[bc*16 +: 16];
      end
    end
  endfunction
  task automatic live(input logic [15:0] m);
    int n;
    n = 0;
    apb(1'b1, `TIS_OFF_MASK, {16'h0, m});
    apb(1'b0, `TIS_OFF_MASK, 32'h0);
    check({16'h0, rdat[15:0]}, {16'h0, m});
    f1 <= a; f2 <= b;
    rank(a, b, m, x1, x2);
    repeat (10) @(posedge clk);
    do begin
      @(negedge clk);
      n++;
    end while (osf !== 1'b0 && n < 8);
    if (n >= 8) begin err_count++; results(); end
    check({o1, o0}, x1[31:0]);
    check({16'h0, o2}, {16'h0, x1[47:32]});
    @(negedge clk);
    check({o1, o0}, x2[31:0]);
    check({16'h0, o2}, {16'h0, x2[47:32]});
  endtask
  task automatic push2(input int bd, input logic [31:0] w0, input logic [31:0] w1);
    apb(1'b1, 8'(`TIS_OFF_INBUF + 4*bd), w0);
    apb(1'b1, 8'(`TIS_OFF_INBUF + 4*bd), w1);
  endtask
  task automatic replay_check(input logic via_cmd, input logic [15:0] e0, input logic [15:0] e1);
    int n;
    n = 0;
    if (via_cmd) begin
      replay_cmd <= 1'b1;
      repeat (4) @(posedge clk);
      replay_cmd <= 1'b0;
    end else begin
      apb(1'b1, `TIS_OFF_CTRL, 32'h3);
    end
    repeat (6) @(posedge clk);
    do begin
      apb(1'b0, `TIS_OFF_STAT, 32'h0);
      n++;
    end while (rdat[`TIS_STAT_BUSY] !== 1'b0 && n < 40);
    if (n >= 40) begin err_count++; results(); end
    repeat (10) @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, 8'(`TIS_OFF_RESBUF + 4*(k/2)), 32'h0);
      check({16'h0, rdat[15:0]}, {16'h0, (k == 0) ? e0 : (k == 1) ? e1 : 16'h0});
    end
    apb(1'b0, `TIS_OFF_STAT, 32'h0);
    check({29'h0, rdat[20:18]}, 32'h7);
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'h4e81fad9));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `TIS_OFF_MASK, 32'h0);
    check({16'h0, rdat[15:0]}, 32'hFFFF);
    apb(1'b0, `TIS_OFF_STAT, 32'h0);
    check({7'h0, rdat[24:0]}, {7'h0, 1'b0, 3'b000, 3'b111, 9'h000, 9'h1FF});
    apb(1'b0, 8'hC0, 32'h0);
    check({31'h0, rerr}, 32'h1);
    a = '0; b = '0;
    live(16'hFFFF);
    for (int c = 0; c < 2*NB; c++) begin
      a[c*16 +: 16] = 16'hA800 | 16'(c); b[c*16 +: 16] = 16'h1000 | 16'(c);
    end
    live(16'hFFFF);
    live(16'h007F);
    a = '0;
    a[5*16 +: 16] = 16'h8003; a[6*16 +: 16] = 16'h007F;
    live(16'hFFFF);
    for (int i = 0; i < 40; i++) begin
      for (int c = 0; c < NB; c++) begin
        a[c*32 +: 32] = $urandom; b[c*32 +: 32] = $urandom;
      end
      live(16'($urandom));
    end
    apb(1'b1, `TIS_OFF_MASK, 32'hFFFF);
    apb(1'b1, `TIS_OFF_CTRL, 32'h5);
    push2(4, 32'h0000_BA85, 32'h0000_3C12);
    apb(1'b0, `TIS_OFF_STAT, 32'h0);
    check({31'h0, rdat[4]}, 32'h0);
    replay_check(1'b0, 16'hBA85, 16'h3C12);
    apb(1'b1, `TIS_OFF_MASK, 32'hFFBF);
    push2(6, 32'hF0F0_0000, 32'h1111_0000);
    push2(2, 32'hC123_0000, 32'h2222_0000);
    replay_check(1'b1, 16'hC123, 16'h2222);
    apb(1'b1, `TIS_OFF_RESBUF + 8'h04, 32'h0000_5A5A);
    apb(1'b0, `TIS_OFF_RESBUF + 8'h04, 32'h0);
    check({16'h0, rdat[15:0]}, 32'h0000_5A5A);
    apb(1'b1, `TIS_OFF_INBUF, 32'h1234_5678);
    apb(1'b0, `TIS_OFF_INBUF, 32'h0);
    check(rdat, 32'h1234_5678);
    results();
  end
endmodule // track_input_sorter_test_fifos_tb_top
